/* common/vector_arbiter_pkg.sv */
// constants shared by the interrupt vector arbiter and its priority encoder
// assumes one core clock domain; all core-side inputs are synchronous to it
package vector_arbiter_pkg;

  // ****************************************************************
  // vector table geometry
  // ****************************************************************
  localparam int PC_W = 15;                  // 32-kbyte program space
  localparam int NUM_RANKS = 16;             // table slots, two bytes each
  localparam int RANK_W = 4;
  localparam int NUM_MASKABLE = 12;          // wired maskable sources
  localparam logic [7:0] OFF_BASE = 8'hE0;   // default entry, lowest rank
  localparam logic [7:0] OFF_TRAP = 8'hFE;   // software trap, highest rank
  localparam logic [7:0] BLOCK_LAST = 8'hFF; // last byte of a 256-byte block

  // ****************************************************************
  // maskable source bit positions in the enable/pending vectors
  // ****************************************************************
  localparam int SRC_EXT_PIN = 11;           // external_irq_pin
  localparam int SRC_IDLE_TIMER = 10;        // idle_timer underflow
  localparam int SRC_T1A = 9;                // timer1_input_a / underflow
  localparam int SRC_T1B = 8;                // timer1_input_b
  localparam int SRC_SERIAL = 7;             // synchronous serial busy low
  localparam int SRC_UART_RX = 6;
  localparam int SRC_UART_TX = 5;
  localparam int SRC_T2A = 4;                // timer2_input_a / underflow
  localparam int SRC_T2B = 3;                // timer2_input_b
  localparam int SRC_T3A = 2;                // timer3_input_a / underflow
  localparam int SRC_T3B = 1;                // timer3_input_b
  localparam int SRC_PORT_WAKE = 0;          // port L edge wakeup

  // ****************************************************************
  // register map, byte addresses on the register bus
  // ****************************************************************
  localparam logic [7:0] ADDR_ENABLE = 8'h00;   // rw, source enables
  localparam logic [7:0] ADDR_STATUS = 8'h04;   // ro, live state
  localparam logic [7:0] ADDR_LAST = 8'h08;     // ro, last selection
  localparam logic [NUM_MASKABLE-1:0] ENABLE_RST = 12'h000;
  localparam int STAT_TRAP_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  localparam int LAST_RANK_LSB = 8;
  localparam int LAST_TGT_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // vector fetch sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HI = 2'h1,
    ST_LO = 2'h3,
    ST_LOAD = 2'h2
  } fetch_state_t;

endpackage : vector_arbiter_pkg

/* design/rank_encoder.sv */
// fixed-priority encoder: highest set bit of the active vector wins
// assumes bit 0 is the default slot, reported when nothing is active
module rank_encoder #(
  parameter int N = 16,
  parameter int W = 4
) (
  input wire logic [N-1:0] active,
  output logic [W-1:0] rank,
  output logic any
);

  // ascending scan so the last (highest) set bit overwrites lower ones
  always_comb begin
    rank = '0;
    any = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (active[i]) begin
        rank = W'(i);
        any = 1'b1;
      end
    end
  end

endmodule : rank_encoder

/* design/interrupt_vector_arbiter.sv */
// vector-select arbitration and two-byte vector fetch for an 8-bit core
// assumes the core pulses vis_start in the first cycle of the instruction,
// program memory answers each read pulse with one rvalid pulse later on,
// and software reaches the enables over an AXI4-Lite slave port
import vector_arbiter_pkg::*;

// Operation
// - on vector-select, choose top enabled-and-pending source and jump through its vector
// - sixteen two-byte entries sit at the top of the instruction's 256-byte block
// - instruction at last byte of a block uses the next block's table
// - vector is 15 bits, high byte at lower address, low byte next
// - software trap ranks highest and always uses offsets FE and FF
// - lowest entry at E0/E1, each higher rank two bytes further up
// - nothing active selects default entry at offset E0
// - trap yields FE, external pin without trap yields FA, lower ranks smaller
// - top ranks: trap, reserved, pin, idle timer, timer1 a/b, serial, reserved
// - then uart rx, uart tx, timer2 a/b, timer3 a/b, port wakeup, default
// - selection uses sources as sampled in the instruction's first cycle
// - offset replaces only the low byte of the counter
// - read the two vector bytes and load them into the program counter
// - vector-select is a single-byte opcode, normally at or after 00FF
// - trap pending flag cleared by reset and by the clear-pending opcode
// - maskable source active only when its enable and pending are both set
// - software trap sets the trap pending flag to one
module interrupt_vector_arbiter (
  input wire logic core_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic vis_start,
  input wire logic [PC_W-1:0] vis_pc,
  input wire logic trap_opcode_exec,
  input wire logic clear_nmi_pending_opcode_exec,
  input wire logic [NUM_MASKABLE-1:0] irq_pending,
  output logic trap_pending_flag,
  output logic vis_busy,
  output logic [PC_W-1:0] vector_ptr,
  // program memory read port
  output logic mem_rd,
  output logic [PC_W-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  // program counter load
  output logic pc_load,
  output logic [PC_W-1:0] pc_value
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [NUM_MASKABLE-1:0] enable_q, enable_d;
  logic trap_q, trap_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  fetch_state_t state_q, state_d;
  logic [RANK_W-1:0] rank_q, rank_d;
  logic [PC_W-1:0] ptr_q, ptr_d;
  logic [7:0] hi_q, hi_d;
  logic mem_rd_q, mem_rd_d;
  logic [PC_W-1:0] mem_addr_q, mem_addr_d;
  logic pc_load_q, pc_load_d;
  logic [PC_W-1:0] pc_value_q, pc_value_d;
  logic busy_q, busy_d;
  logic [RANK_W-1:0] last_rank_q, last_rank_d;
  logic [7:0] last_off_q, last_off_d;
  logic [PC_W-1:0] last_tgt_q, last_tgt_d;
  logic [NUM_MASKABLE-1:0] act;
  logic [NUM_RANKS-1:0] active16;
  logic [RANK_W-1:0] enc_rank;
  logic [6:0] table_block;
  logic [7:0] sel_offset;

  // ****************************************************************
  // arbitration
  // ****************************************************************
  // the global enable plays no part here; the core gates entry itself
  assign act = enable_q & irq_pending;

  // reserved slots tied low, default slot left low so an empty set encodes 0
  assign active16 = {trap_q, 1'b0, act[SRC_EXT_PIN:SRC_SERIAL], 1'b0,
                     act[SRC_UART_RX:SRC_PORT_WAKE], 1'b0};

  rank_encoder #(
    .N(NUM_RANKS),
    .W(RANK_W)
  ) u_rank_encoder (
    .active(active16),
    .rank(enc_rank),
    .any()
  );

  // a vector-select at the last byte of a block points into the next block
  assign table_block = (vis_pc[7:0] == BLOCK_LAST) ? vis_pc[14:8] + 7'h01
                                                   : vis_pc[14:8];
  assign sel_offset = OFF_BASE + {3'h0, enc_rank, 1'b0};

  // ****************************************************************
  // trap pending flag
  // ****************************************************************
  // a trap in the same cycle as a clear leaves the flag set
  always_comb begin
    trap_d = trap_q;
    if (clear_nmi_pending_opcode_exec) begin
      trap_d = 1'b0;
    end
    if (trap_opcode_exec) begin
      trap_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= trap_d;
    end
  end

  // ****************************************************************
  // vector fetch sequencer
  // ****************************************************************
  // starts taken while a fetch runs are dropped; the core cannot issue them
  always_comb begin
    state_d = state_q;
    rank_d = rank_q;
    ptr_d = ptr_q;
    hi_d = hi_q;
    mem_rd_d = 1'b0;
    mem_addr_d = mem_addr_q;
    pc_load_d = 1'b0;
    pc_value_d = pc_value_q;
    last_rank_d = last_rank_q;
    last_off_d = last_off_q;
    last_tgt_d = last_tgt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (vis_start) begin
          rank_d = enc_rank;
          ptr_d = {table_block, sel_offset};
          mem_rd_d = 1'b1;
          mem_addr_d = {table_block, sel_offset};
          state_d = ST_HI;
        end
      end
      ST_HI: begin
        if (mem_rvalid) begin
          hi_d = mem_rdata;
          mem_rd_d = 1'b1;
          mem_addr_d = {ptr_q[14:1], 1'b1};
          state_d = ST_LO;
        end
      end
      ST_LO: begin
        if (mem_rvalid) begin
          pc_value_d = {hi_q[6:0], mem_rdata};
          pc_load_d = 1'b1;
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        last_rank_d = rank_q;
        last_off_d = ptr_q[7:0];
        last_tgt_d = pc_value_q;
        state_d = ST_IDLE;
      end
    endcase
    // busy is registered so the core sees a clean flop output, not a decode
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      rank_q <= '0;
      ptr_q <= '0;
      hi_q <= 8'h00;
      mem_rd_q <= 1'b0;
      mem_addr_q <= '0;
      pc_load_q <= 1'b0;
      pc_value_q <= '0;
      last_rank_q <= '0;
      last_off_q <= OFF_BASE;
      last_tgt_q <= '0;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      rank_q <= rank_d;
      ptr_q <= ptr_d;
      hi_q <= hi_d;
      mem_rd_q <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      pc_load_q <= pc_load_d;
      pc_value_q <= pc_value_d;
      last_rank_q <= last_rank_d;
      last_off_q <= last_off_d;
      last_tgt_q <= last_tgt_d;
    end
  end

  // ****************************************************************
  // register bus, write side
  // ****************************************************************
  // address and data may arrive in either order; each is parked until
  // its partner shows up, then one response is raised
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    enable_d = enable_q;
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (waddr_q[7:2])
        ADDR_ENABLE[7:2]: begin
          if (wstrb_q[0]) begin
            enable_d[7:0] = wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            enable_d[11:8] = wdata_q[11:8];
          end
        end
        ADDR_STATUS[7:2], ADDR_LAST[7:2]: begin
          bresp_d = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      enable_q <= ENABLE_RST;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      enable_q <= enable_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  // ****************************************************************
  // register bus, read side
  // ****************************************************************
  // status is sampled at the address handshake, one cycle before rvalid
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h00000000;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        ADDR_ENABLE[7:2]: begin
          rdata_d[NUM_MASKABLE-1:0] = enable_q;
        end
        ADDR_STATUS[7:2]: begin
          rdata_d[NUM_MASKABLE-1:0] = irq_pending;
          rdata_d[STAT_TRAP_BIT] = trap_q;
          rdata_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
        end
        ADDR_LAST[7:2]: begin
          rdata_d[7:0] = last_off_q;
          rdata_d[LAST_RANK_LSB +: RANK_W] = last_rank_q;
          rdata_d[LAST_TGT_LSB +: PC_W] = last_tgt_q;
        end
        default: begin
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arready_q <= arready_d;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign trap_pending_flag = trap_q;
  assign vector_ptr = ptr_q;
  assign mem_rd = mem_rd_q;
  assign mem_addr = mem_addr_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_value_q;
  // busy covers the whole fetch so the core holds off its next vis_start
  assign vis_busy = busy_q;

endmodule : interrupt_vector_arbiter

/* sim/vector_arbiter_checker.sv */
// concurrent checks on the core-side and fetch ports of the arbiter
// assumes a bind into interrupt_vector_arbiter, one clock domain
module vector_arbiter_checker
  import vector_arbiter_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic vis_start,
  input wire logic [PC_W-1:0] vis_pc,
  input wire logic trap_opcode_exec,
  input wire logic clear_nmi_pending_opcode_exec,
  input wire logic [NUM_MASKABLE-1:0] irq_pending,
  input wire logic trap_pending_flag,
  input wire logic vis_busy,
  input wire logic [PC_W-1:0] vector_ptr,
  input wire logic mem_rd,
  input wire logic [PC_W-1:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic pc_load
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic take;
  // a start only counts while the sequencer is idle
  assign take = vis_start && !vis_busy;
  a_trap_wins: assert property (take && trap_pending_flag |=> vector_ptr[7:0] == OFF_TRAP)
    else $error("trap offset not chosen");
  a_idle_default: assert property (take && !trap_pending_flag && irq_pending == '0
    |=> vector_ptr[7:0] == OFF_BASE) else $error("default offset not chosen");
  a_block_pick: assert property (take |=> vector_ptr[14:8] ==
    7'($past(vis_pc[14:8]) + ($past(vis_pc[7:0]) == BLOCK_LAST))) else $error("wrong block");
  a_ptr_form: assert property (take |=> !vector_ptr[0] && vector_ptr[7:5] == 3'h7 && vis_busy)
    else $error("pointer offset malformed");
  a_first_read: assert property (take |=> mem_rd && mem_addr == vector_ptr)
    else $error("first byte read wrong");
  a_second_read: assert property (vis_busy && mem_rvalid && !mem_addr[0]
    |=> mem_rd && mem_addr == (vector_ptr | 15'h0001)) else $error("second byte read wrong");
  a_load_done: assert property (pc_load |-> vis_busy ##1 !vis_busy)
    else $error("busy not released after load");
  a_ptr_hold: assert property (vis_busy && $past(vis_busy) |-> $stable(vector_ptr))
    else $error("pointer moved mid fetch");
  a_no_reserved: assert property (vis_busy |-> !(vector_ptr[7:0] inside {8'hFC, 8'hF0}))
    else $error("reserved slot chosen");
  a_trap_set: assert property (trap_opcode_exec |=> trap_pending_flag)
    else $error("trap flag not set");
  a_trap_clear: assert property (clear_nmi_pending_opcode_exec && !trap_opcode_exec
    |=> !trap_pending_flag) else $error("trap flag not cleared");
  c_trap: cover property (take && trap_pending_flag);
  c_default: cover property (take && irq_pending == '0);
  c_load: cover property (pc_load);
endmodule : vector_arbiter_checker

bind interrupt_vector_arbiter vector_arbiter_checker chk_u (.*);

/* sim/prog_mem_model.sv */
// program memory stand-in for the byte-wide vector fetch port
// assumes one read in flight; mem_slow picks the latency of each read
module prog_mem_model
  import vector_arbiter_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mem_rd,
  input wire logic [PC_W-1:0] mem_addr,
  input wire logic mem_slow,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend_q;
  logic [1:0] wait_q;
  logic [PC_W-1:0] addr_q;
  // data flips every cycle it is not answering, so a sample one cycle late reads the complement
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      wait_q <= 2'h0;
      addr_q <= '0;
      mem_rdata <= 8'h00;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd) begin
        pend_q <= 1'b1;
        addr_q <= mem_addr;
        wait_q <= mem_slow ? 2'h3 : 2'h0;
      end else if (pend_q && wait_q == 2'h0) begin
        pend_q <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= addr_q[7:0] ^ addr_q[14:7]; // each byte at its own address
      end else if (pend_q) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule : prog_mem_model

/* sim/interrupt_vector_arbiter_test.sv */
// bench: register bus, trap flag and vector fetch of the arbiter
// assumes prog_mem_model on the fetch port and the bound checker
module interrupt_vector_arbiter_test
  import vector_arbiter_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, vis_start, trap_opcode_exec, clear_nmi_pending_opcode_exec;
  logic trap_pending_flag, vis_busy, mem_rd, mem_rvalid, pc_load, mem_slow, trap_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mem_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, last_w, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [PC_W-1:0] vis_pc, vector_ptr, mem_addr, pc_value;
  logic [NUM_MASKABLE-1:0] irq_pending, en_q;
  logic [31:0] rng_q = 32'h00018401;
  logic [33:0] rq[$];
  logic [29:0] vq[$], e;
  int err_count = 0, n_checks = 0, cyc = 0;
  interrupt_vector_arbiter dut_u (.*);
  prog_mem_model mem_u (.*);
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction : rnd
  function automatic logic [7:0] mdat(input logic [PC_W-1:0] a);
    return a[7:0] ^ a[14:7];
  endfunction : mdat
  // expected offset: ascending scan so the highest active rank lands last
  function automatic logic [7:0] exp_off(input logic tr, input logic [11:0] act);
    logic [7:0] o;
    o = OFF_BASE;
    for (int b = 0; b < NUM_MASKABLE; b++) begin
      if (act[b]) o = OFF_BASE + 8'(2 * (b >= 7 ? b + 2 : b + 1));
    end
    if (tr) o = OFF_TRAP;
    return o;
  endfunction : exp_off
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    rq.push_back({er, d});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // dbl keeps the start high one more cycle, which a busy sequencer must ignore
  task automatic vector_select_instruction(input logic [PC_W-1:0] pc, input logic [11:0] pend, input logic dbl);
    logic [7:0] o, h;
    logic [PC_W-1:0] p;
    o = exp_off(trap_q, en_q & pend);
    p = {7'(pc[14:8] + (pc[7:0] == BLOCK_LAST)), o};
    h = mdat(p);
    vq.push_back({p, h[6:0], mdat(p | 15'h0001)});
    last_w = {1'b0, h[6:0], mdat(p | 15'h0001), 4'h0, 4'((o - OFF_BASE) >> 1), o};
    r = rnd();
    @(posedge core_clk);
    vis_start <= 1'b1;
    vis_pc <= pc;
    irq_pending <= pend;
    mem_slow <= r[31];
    @(posedge core_clk);
    vis_start <= dbl;
    irq_pending <= r[11:0]; // later changes must not move the choice
    @(posedge core_clk);
    vis_start <= 1'b0;
    do @(posedge core_clk); while (vis_busy);
  endtask : vector_select_instruction
  task automatic pulse(input logic clr);
    @(posedge core_clk);
    if (clr) clear_nmi_pending_opcode_exec <= 1'b1;
    else trap_opcode_exec <= 1'b1;
    @(posedge core_clk);
    clear_nmi_pending_opcode_exec <= 1'b0;
    trap_opcode_exec <= 1'b0;
    trap_q = !clr;
  endtask : pulse
  // ****************
  // clock, watchdog and result monitor
  // ****************
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", rq[0][31:0], s_axi_rdata);
      chk("rresp", {30'h0, rq[0][33:32]}, {30'h0, s_axi_rresp});
      rq.pop_front();
    end
    if (pc_load && vq.size() == 0) chk("extra pc_load", 32'h0, 32'h1);
    else if (pc_load) begin
      e = vq.pop_front();
      chk("vector_ptr", {17'h0, e[29:15]}, {17'h0, vector_ptr});
      chk("pc_value", {17'h0, e[14:0]}, {17'h0, pc_value});
    end
  end
  initial begin
    {core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, vis_start, trap_opcode_exec, clear_nmi_pending_opcode_exec} = '0;
    {mem_slow, trap_q, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {vis_pc, irq_pending, en_q} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    axi_rd(ADDR_ENABLE, 32'h0, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    axi_rd(8'h0C, 32'h0, RESP_SLVERR);
    axi_wr(8'h10, 32'h00000FFF, 4'hF, RESP_SLVERR);
    axi_wr(ADDR_ENABLE, 32'h00000FFF, 4'h2, RESP_OKAY);
    axi_rd(ADDR_ENABLE, 32'h00000F00, RESP_OKAY);
    axi_wr(ADDR_ENABLE, 32'h00000FFF, 4'h1, RESP_OKAY);
    en_q = 12'hFFF;
    vector_select_instruction(15'h0123, 12'h000, 1'b0);
    for (int b = 0; b < NUM_MASKABLE; b++) vector_select_instruction(15'(rnd()), 12'(1 << b), b == 3);
    vector_select_instruction(15'h00FF, 12'h800, 1'b0);
    vector_select_instruction(15'h7FFF, 12'h401, 1'b0);
    vector_select_instruction(15'h01DF, 12'h0C0, 1'b0);
    pulse(1'b0);
    axi_rd(ADDR_STATUS, {15'h0, 1'b1, 4'h0, irq_pending}, RESP_OKAY);
    vector_select_instruction(15'h0456, 12'hFFF, 1'b0);
    axi_rd(ADDR_LAST, last_w, RESP_OKAY);
    pulse(1'b1);
    axi_rd(ADDR_STATUS, {20'h0, irq_pending}, RESP_OKAY);
    axi_wr(ADDR_ENABLE, 32'h000000F0, 4'h3, RESP_OKAY);
    en_q = 12'h0F0;
    vector_select_instruction(15'h0777, 12'hF0F, 1'b0);
    repeat (16) begin
      r = rnd();
      en_q = r[27:16];
      axi_wr(ADDR_ENABLE, {20'h0, en_q}, 4'h3, RESP_OKAY);
      vector_select_instruction(r[14:0], 12'(rnd()), 1'b0);
    end
    repeat (3) @(posedge core_clk);
    // a start the sequencer never took leaves its note behind
    chk("unanswered vis", 32'h0, 32'(vq.size()));
    report_and_stop();
  end
endmodule : interrupt_vector_arbiter_test
